// *** rtl/coad_alu16.v ***
// Sixteen-bit adder used for pointer, jump and pair arithmetic
`timescale 1ns/1ps
`default_nettype none

module coad_alu16 #(
  parameter WIDTH = 16
) (
  input  wire [WIDTH-1:0] i_a,
  input  wire [WIDTH-1:0] i_b,
  input  wire             i_cin,
  output wire [WIDTH-1:0] o_sum,
  output wire             o_cout
);

  wire [WIDTH:0] full_sum;

  // Wraps modulo 2**WIDTH; carry kept for the pair-add flags
  assign full_sum = {1'b0, i_a} + {1'b0, i_b} + {{WIDTH{1'b0}}, i_cin};
  assign o_sum    = full_sum[WIDTH-1:0];
  assign o_cout   = full_sum[WIDTH];

endmodule

`default_nettype wire

// *** rtl/coad_decoder.v ***
// Operand addressing and instruction-group decode for an 8-bit core
// Function
// - register operands chosen straight from opcode fields, no extra bytes
// - implied arithmetic always writes its result to the accumulator
// - immediate mode fetches one byte after opcode as 8-bit data
// - immediate extended fetches two bytes forming a 16-bit pair value
// - direct mode forms address from bytes two and three; jump loads PC
// - register indirect uses pair contents as address; 86h adds memory to A
// - indexed address is index register plus instruction displacement
// - relative jump target is program location plus displacement
// - restart calls one of eight addresses 00h to 38h from 3-bit field
// - set, clear or test a chosen bit of register or memory byte
// - compare_up_repeat compares, bumps pointer up, counts down to zero
// - compare_down_repeat compares, moves pointer down, counts to zero
// - invert_accumulator replaces accumulator with its one's complement
// - 16-bit add-with-carry adds pair plus carry into pointer pair
// - conditional call jumps only when condition true, else continues
// - 16-bit decrement reduces the chosen pair by one
// - displacement bytes are signed two's-complement values
// - condition codes NZ,Z,NC,C,PO,PE,P,M encoded upward from 000
`timescale 1ns/1ps
`default_nettype none
`include "coad_defines.vh"

module coad_decoder #(
  parameter AW = 16,
  parameter DW = 8
) (
  input  wire          i_core_clk,
  input  wire          i_rst,
  input  wire [DW-1:0] i_mem_rdata,
  input  wire          i_mem_ready,
  output reg  [AW-1:0] o_mem_addr,
  output reg  [DW-1:0] o_mem_wdata,
  output reg           o_mem_rd,
  output reg           o_mem_wr,
  output reg  [AW-1:0] o_pc,
  output reg  [DW-1:0] o_acc,
  output reg  [DW-1:0] o_flags,
  output reg  [AW-1:0] o_memory_pointer_pair,
  output reg  [AW-1:0] o_byte_counter_pair,
  output reg           o_instr_done,
  output reg           o_illegal
);

  localparam S_FETCH = 4'h0;
  localparam S_OPER1 = 4'h1;
  localparam S_OPER2 = 4'h2;
  localparam S_MREAD = 4'h3;
  localparam S_MWRIT = 4'h4;
  localparam S_PUSHH = 4'h5;
  localparam S_PUSHL = 4'h6;
  localparam S_EXEC  = 4'h7;
  localparam S_CBOP  = 4'h8;
  localparam S_EDOP  = 4'h9;

  reg [3:0]    state;
  reg [DW-1:0] regs [0:7];
  reg [AW-1:0] sp;
  reg [AW-1:0] ix;
  reg [AW-1:0] iy;
  reg [DW-1:0] op;
  reg [1:0]    idx_sel;
  reg [DW-1:0] lo;
  reg [DW-1:0] disp;
  reg [AW-1:0] target;

  // Signed displacement for relative and indexed forms
  function [AW-1:0] sext;
    input [DW-1:0] d;
    begin
      sext = {{(AW-DW){d[DW-1]}}, d};
    end
  endfunction

  function cond_true;
    input [2:0]    cc;
    input [DW-1:0] f;
    begin
      case (cc[2:1])
        2'h0:    cond_true = f[`COAD_FLAG_Z]  ^ ~cc[0];
        2'h1:    cond_true = f[`COAD_FLAG_C]  ^ ~cc[0];
        2'h2:    cond_true = f[`COAD_FLAG_PV] ^ ~cc[0];
        default: cond_true = f[`COAD_FLAG_S]  ^ ~cc[0];
      endcase
    end
  endfunction

  function [AW-1:0] pair_rd;
    input [1:0]    sel;
    input [DW-1:0] b0, b1, b2, b3, b4, b5;
    input [AW-1:0] s;
    begin
      case (sel)
        `COAD_PAIR_BC: pair_rd = {b0, b1};
        `COAD_PAIR_DE: pair_rd = {b2, b3};
        `COAD_PAIR_HL: pair_rd = {b4, b5};
        default:       pair_rd = s;
      endcase
    end
  endfunction

  wire [AW-1:0] hl = {regs[`COAD_REG_H], regs[`COAD_REG_L]};
  wire [AW-1:0] bc = {regs[`COAD_REG_B], regs[`COAD_REG_C]};
  wire [AW-1:0] pair_op = pair_rd(op[5:4], regs[0], regs[1], regs[2],
                                  regs[3], regs[4], regs[5], sp);
  // ED second byte is still on the bus while the pair is chosen
  wire [AW-1:0] pair_ed = pair_rd(i_mem_rdata[5:4], regs[0], regs[1],
                                  regs[2], regs[3], regs[4], regs[5], sp);
  wire [AW-1:0] base = (idx_sel == 2'h1) ? ix :
                       (idx_sel == 2'h2) ? iy : hl;

  reg  [AW-1:0] add_a;
  reg  [AW-1:0] add_b;
  reg           add_c;
  wire [AW-1:0] add_s;
  wire          add_co;

  always @* begin
    add_a = o_pc;
    add_b = sext(i_mem_rdata);
    add_c = 1'b0;
    if (state == S_EDOP && i_mem_rdata[3:0] == 4'hA) begin
      add_a = hl;
      add_b = pair_ed;
      add_c = o_flags[`COAD_FLAG_C];
    end else if (state == S_EXEC && op[3:0] == 4'hB) begin
      add_a = pair_op;
      add_b = {AW{1'b1}};
    end else if (idx_sel != 2'h0) begin
      add_a = base;
      add_b = sext(disp);
    end
  end

  coad_alu16 #(
    .WIDTH (AW)
  ) u_add (
    .i_a    (add_a),
    .i_b    (add_b),
    .i_cin  (add_c),
    .o_sum  (add_s),
    .o_cout (add_co)
  );

  // Shared 8-bit ALU; destination fixed to A by the caller
  reg  [DW-1:0] alu_r;
  wire [DW:0]   diff = {1'b0, o_acc} - {1'b0, i_mem_rdata};
  // Register operand in the execute cycle, memory byte otherwise
  wire [DW-1:0] alu_b = (state != S_EXEC) ? i_mem_rdata :
                        (op[2:0] == `COAD_REG_A) ? o_acc : regs[op[2:0]];
  always @* begin
    case (op[5:3])
      3'h0:    alu_r = o_acc + alu_b;
      3'h1:    alu_r = o_acc + alu_b + {7'h00, o_flags[0]};
      3'h2:    alu_r = o_acc - alu_b;
      3'h3:    alu_r = o_acc - alu_b - {7'h00, o_flags[0]};
      3'h4:    alu_r = o_acc & alu_b;
      3'h5:    alu_r = o_acc ^ alu_b;
      3'h6:    alu_r = o_acc | alu_b;
      default: alu_r = o_acc;
    endcase
  end

  wire [DW-1:0] bit_mask = 8'h01 << op[5:3];
  // Accumulator lives outside the register file
  wire [2:0]    cb_r     = i_mem_rdata[2:0];
  wire [DW-1:0] cb_mask  = 8'h01 << i_mem_rdata[5:3];
  wire [DW-1:0] cb_src   = (cb_r == `COAD_REG_A) ? o_acc : regs[cb_r];
  wire          pc_edge  = i_mem_ready & o_mem_rd;
  wire [AW-1:0] bc_dec   = bc - 16'h0001;
  integer k;

  always @(posedge i_core_clk) begin
    o_instr_done <= 1'b0;
    o_memory_pointer_pair <= hl;
    o_byte_counter_pair   <= bc;
    if (i_rst) begin
      state <= S_FETCH;
      for (k = 0; k < 8; k = k + 1)
        regs[k] <= 8'h00;
      sp <= `COAD_SP_RESET;
      ix <= 16'h0000;
      iy <= 16'h0000;
      op <= 8'h00;
      idx_sel <= 2'h0;
      lo <= 8'h00;
      disp <= 8'h00;
      target <= 16'h0000;
      o_pc <= `COAD_PC_RESET;
      o_acc <= 8'h00;
      o_flags <= 8'h00;
      o_mem_addr <= `COAD_PC_RESET;
      o_mem_wdata <= 8'h00;
      o_mem_rd <= 1'b1;
      o_mem_wr <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      case (state)
        S_FETCH: if (pc_edge) begin
          o_pc <= o_pc + 16'h0001;
          o_mem_addr <= o_pc + 16'h0001;
          op <= i_mem_rdata;
          if (i_mem_rdata == `COAD_PFX_DD)
            idx_sel <= 2'h1;
          else if (i_mem_rdata == `COAD_PFX_FD)
            idx_sel <= 2'h2;
          else if (i_mem_rdata == `COAD_PFX_CB)
            state <= S_CBOP;
          else if (i_mem_rdata == `COAD_PFX_ED)
            state <= S_EDOP;
          else begin
            // Bus idles while the opcode decodes, so no request moves
            state <= S_EXEC;
            o_mem_rd <= 1'b0;
          end
        end
        S_EXEC: begin
          o_mem_rd <= 1'b0;
          state <= S_OPER1;
          if (op[7:6] == 2'h1 && op[5:3] != `COAD_REG_MEM
              && op[2:0] != `COAD_REG_MEM) begin
            if (op[5:3] == `COAD_REG_A)
              o_acc <= (op[2:0] == `COAD_REG_A) ? o_acc : regs[op[2:0]];
            else
              regs[op[5:3]] <= (op[2:0] == `COAD_REG_A) ? o_acc
                               : regs[op[2:0]];
            state <= S_FETCH;
            o_mem_addr <= o_pc;
            o_mem_rd <= 1'b1;
            o_instr_done <= 1'b1;
          end else if (op[7:6] == 2'h2 && op[2:0] != `COAD_REG_MEM) begin
            o_acc <= alu_r;
            state <= S_FETCH;
            o_mem_addr <= o_pc;
            o_mem_rd <= 1'b1;
            o_instr_done <= 1'b1;
          end else if (op == `COAD_OP_CPL) begin
            o_acc <= ~o_acc;
            state <= S_FETCH;
            o_mem_addr <= o_pc;
            o_mem_rd <= 1'b1;
            o_instr_done <= 1'b1;
          end else if (op[7:6] == 2'h0 && op[3:0] == 4'hB) begin
            if (op[5:4] == `COAD_PAIR_SP)
              sp <= add_s;
            else begin
              regs[{op[5:4], 1'b0}] <= add_s[15:8];
              regs[{op[5:4], 1'b1}] <= add_s[7:0];
            end
            state <= S_FETCH;
            o_mem_addr <= o_pc;
            o_mem_rd <= 1'b1;
            o_instr_done <= 1'b1;
          end else if (op[7:6] == 2'h3 && op[2:0] == 3'h7) begin
            target <= {8'h00, 2'h0, op[5:3], 3'h0};
            o_mem_addr <= sp - 16'h0001;
            o_mem_wdata <= o_pc[15:8];
            o_mem_wr <= 1'b1;
            sp <= sp - 16'h0001;
            state <= S_PUSHL;
          end else if (op == `COAD_OP_ADD_MEM || op[7:6] == 2'h2 ||
                       (op[7:6] == 2'h1 && op[2:0] == `COAD_REG_MEM)) begin
            o_mem_addr <= (idx_sel != 2'h0) ? o_pc : hl;
            o_mem_rd <= 1'b1;
            state <= (idx_sel != 2'h0) ? S_OPER1 : S_MREAD;
          end else begin
            o_mem_addr <= o_pc;
            o_mem_rd <= 1'b1;
          end
        end
        S_OPER1: if (pc_edge) begin
          o_pc <= o_pc + 16'h0001;
          o_mem_addr <= o_pc + 16'h0001;
          lo <= i_mem_rdata;
          disp <= i_mem_rdata;
          state <= S_OPER2;
          if (idx_sel != 2'h0 && (op[7:6] == 2'h2 || op[7:6] == 2'h1)) begin
            o_mem_addr <= base + sext(i_mem_rdata);
            state <= S_MREAD;
          end else if (op[7:6] == 2'h0 && op[2:0] == 3'h6) begin
            regs[op[5:3]] <= i_mem_rdata;
            if (op[5:3] == `COAD_REG_A)
              o_acc <= i_mem_rdata;
            o_mem_rd <= 1'b1;
            state <= S_FETCH;
            o_instr_done <= 1'b1;
          end else if (op == `COAD_OP_JR || (op[7:5] == 3'h1 &&
                       op[2:0] == 3'h0)) begin
            if (op == `COAD_OP_JR || cond_true({1'b0, op[4:3]}, o_flags)) begin
              o_pc <= add_s + 16'h0001;
              o_mem_addr <= add_s + 16'h0001;
            end
            state <= S_FETCH;
            o_instr_done <= 1'b1;
          end
        end
        S_OPER2: if (pc_edge) begin
          o_pc <= o_pc + 16'h0001;
          o_mem_addr <= o_pc + 16'h0001;
          state <= S_FETCH;
          o_instr_done <= 1'b1;
          if (op[7:6] == 2'h0 && op[3:0] == 4'h1) begin
            if (idx_sel == 2'h1)
              ix <= {i_mem_rdata, lo};
            else if (idx_sel == 2'h2)
              iy <= {i_mem_rdata, lo};
            else if (op[5:4] == `COAD_PAIR_SP)
              sp <= {i_mem_rdata, lo};
            else begin
              regs[{op[5:4], 1'b0}] <= i_mem_rdata;
              regs[{op[5:4], 1'b1}] <= lo;
            end
          end else if (op == `COAD_OP_JP || (op[7:6] == 2'h3 &&
                       op[2:0] == 3'h2 && cond_true(op[5:3], o_flags))) begin
            o_pc <= {i_mem_rdata, lo};
            o_mem_addr <= {i_mem_rdata, lo};
          end else if (op == `COAD_OP_CALL || (op[7:6] == 2'h3 &&
                       op[2:0] == 3'h4 && cond_true(op[5:3], o_flags))) begin
            target <= {i_mem_rdata, lo};
            o_mem_rd <= 1'b0;
            o_mem_addr <= sp - 16'h0001;
            o_mem_wdata <= o_pc[15:8] + {7'h00, &o_pc[7:0]};
            o_mem_wr <= 1'b1;
            sp <= sp - 16'h0001;
            o_instr_done <= 1'b0;
            state <= S_PUSHL;
          end
          idx_sel <= 2'h0;
        end
        S_PUSHL: if (i_mem_ready) begin
          o_mem_addr <= sp - 16'h0001;
          o_mem_wdata <= o_pc[7:0];
          sp <= sp - 16'h0001;
          state <= S_PUSHH;
        end
        S_PUSHH: if (i_mem_ready) begin
          o_mem_wr <= 1'b0;
          o_pc <= target;
          o_mem_addr <= target;
          o_mem_rd <= 1'b1;
          state <= S_FETCH;
          o_instr_done <= 1'b1;
        end
        S_MREAD: if (pc_edge) begin
          o_mem_addr <= o_pc;
          state <= S_FETCH;
          o_instr_done <= 1'b1;
          idx_sel <= 2'h0;
          if (op[7:6] == 2'h2)
            o_acc <= alu_r;
          else if (op[7:6] == 2'h1 && op[5:3] == `COAD_REG_A)
            o_acc <= i_mem_rdata;
          else if (op[7:6] == 2'h1)
            regs[op[5:3]] <= i_mem_rdata;
          else if (op[7:6] == 2'h0) begin
            o_flags[`COAD_FLAG_Z] <= ~|(i_mem_rdata & bit_mask);
          end else begin
            o_flags[`COAD_FLAG_Z] <= (diff[7:0] == 8'h00);
            o_flags[`COAD_FLAG_PV] <= (bc_dec != 16'h0000);
            regs[`COAD_REG_B] <= bc_dec[15:8];
            regs[`COAD_REG_C] <= bc_dec[7:0];
            regs[`COAD_REG_H] <= op[3] ? hl[15:8] - {7'h00, ~|hl[7:0]}
                                       : hl[15:8] + {7'h00, &hl[7:0]};
            regs[`COAD_REG_L] <= op[3] ? hl[7:0] - 8'h01 : hl[7:0] + 8'h01;
            if (bc_dec != 16'h0000 && diff[7:0] != 8'h00) begin
              o_pc <= o_pc - 16'h0002;
              o_mem_addr <= o_pc - 16'h0002;
            end
          end
        end
        S_CBOP: if (pc_edge) begin
          o_pc <= o_pc + 16'h0001;
          op <= i_mem_rdata;
          if (i_mem_rdata[2:0] == `COAD_REG_MEM) begin
            o_mem_addr <= hl;
            state <= (i_mem_rdata[7:6] == 2'h1) ? S_MREAD : S_MWRIT;
            if (i_mem_rdata[7:6] == 2'h1)
              op <= {2'h0, i_mem_rdata[5:0]};
          end else begin
            o_mem_addr <= o_pc + 16'h0001;
            state <= S_FETCH;
            o_instr_done <= 1'b1;
            case (i_mem_rdata[7:6])
              2'h1: o_flags[`COAD_FLAG_Z] <= ~|(cb_src & cb_mask);
              2'h2: begin
                if (cb_r == `COAD_REG_A)
                  o_acc <= o_acc & ~cb_mask;
                else
                  regs[cb_r] <= cb_src & ~cb_mask;
              end
              2'h3: begin
                if (cb_r == `COAD_REG_A)
                  o_acc <= o_acc | cb_mask;
                else
                  regs[cb_r] <= cb_src | cb_mask;
              end
              default: o_illegal <= 1'b1;
            endcase
          end
        end
        S_MWRIT: if (pc_edge) begin
          o_mem_rd <= 1'b0;
          o_mem_wr <= 1'b1;
          o_mem_wdata <= op[6] ? (i_mem_rdata | bit_mask)
                               : (i_mem_rdata & ~bit_mask);
          state <= S_PUSHH;
          target <= o_pc;
        end
        S_EDOP: if (pc_edge) begin
          o_pc <= o_pc + 16'h0001;
          o_mem_addr <= o_pc + 16'h0001;
          op <= i_mem_rdata;
          state <= S_FETCH;
          o_instr_done <= 1'b1;
          if (i_mem_rdata == `COAD_OP_COMPARE_UP_REPEAT || i_mem_rdata == `COAD_OP_COMPARE_DOWN_REPEAT)
          begin
            o_mem_addr <= hl;
            op <= {2'h3, i_mem_rdata[5:0]};
            state <= S_MREAD;
            o_instr_done <= 1'b0;
          end else if (i_mem_rdata[7:6] == 2'h1 &&
                       i_mem_rdata[3:0] == 4'hA) begin
            regs[`COAD_REG_H] <= add_s[15:8];
            regs[`COAD_REG_L] <= add_s[7:0];
            o_flags[`COAD_FLAG_C] <= add_co;
            o_flags[`COAD_FLAG_Z] <= (add_s == 16'h0000);
          end else
            o_illegal <= 1'b1;
        end
        default: state <= S_FETCH;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** rtl/coad_defines.vh ***
// Constants for the operand addressing and instruction-group decoder
`ifndef COAD_DEFINES_VH
`define COAD_DEFINES_VH

`define COAD_REG_B        3'h0
`define COAD_REG_C        3'h1
`define COAD_REG_D        3'h2
`define COAD_REG_E        3'h3
`define COAD_REG_H        3'h4
`define COAD_REG_L        3'h5
`define COAD_REG_MEM      3'h6
`define COAD_REG_A        3'h7

`define COAD_PAIR_BC      2'h0
`define COAD_PAIR_DE      2'h1
`define COAD_PAIR_HL      2'h2
`define COAD_PAIR_SP      2'h3

`define COAD_FLAG_C       0
`define COAD_FLAG_PV      2
`define COAD_FLAG_Z       6
`define COAD_FLAG_S       7

`define COAD_PFX_CB       8'hCB
`define COAD_PFX_ED       8'hED
`define COAD_PFX_DD       8'hDD
`define COAD_PFX_FD       8'hFD

`define COAD_OP_ADD_MEM   8'h86
`define COAD_OP_JP        8'hC3
`define COAD_OP_JR        8'h18
`define COAD_OP_CALL      8'hCD
`define COAD_OP_CPL       8'h2F
`define COAD_OP_COMPARE_UP_REPEAT      8'hB1
`define COAD_OP_COMPARE_DOWN_REPEAT      8'hB9

`define COAD_RST_STEP     8'h08
`define COAD_PC_RESET     16'h0000
`define COAD_SP_RESET     16'hFFFF

`endif

// *** verification/coad_decoder_chk.sv ***
// Concurrent checks on the decoder's memory bus and result ports
`timescale 1ns/1ps
`default_nettype none
module coad_decoder_chk #(
  parameter AW = 16,
  parameter DW = 8
) (
  input wire logic          i_core_clk,
  input wire logic          i_rst,
  input wire logic          i_mem_ready,
  input wire logic [AW-1:0] o_mem_addr,
  input wire logic [DW-1:0] o_mem_wdata,
  input wire logic          o_mem_rd,
  input wire logic          o_mem_wr,
  input wire logic [AW-1:0] o_pc,
  input wire logic [DW-1:0] o_acc,
  input wire logic [DW-1:0] o_flags,
  input wire logic          o_instr_done,
  input wire logic          o_illegal
);
  chk_reset_state: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(i_rst) |-> o_pc == 0 && o_mem_addr == 0 && o_mem_rd && !o_mem_wr
      && o_acc == 0 && o_flags == 0 && !o_instr_done)
    else $error("state after reset wrong");
  chk_read_holds: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_mem_rd && !i_mem_ready |=> o_mem_rd && $stable(o_mem_addr))
    else $error("read request dropped or moved while stalled");
  chk_write_holds: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_mem_wr && !i_mem_ready |=> o_mem_wr && $stable(o_mem_addr)
      && $stable(o_mem_wdata))
    else $error("write request dropped or moved while stalled");
  chk_one_request: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(o_mem_rd && o_mem_wr))
    else $error("read and write requested together");
  chk_stall_no_done: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    o_mem_rd && !i_mem_ready |=> !o_instr_done)
    else $error("instruction completed during a stalled read");
  chk_illegal_sticky: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    o_illegal |=> o_illegal)
    else $error("illegal flag cleared without reset");
  chk_bus_resumes: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_mem_rd && !o_mem_wr |-> ##[1:16] (o_mem_rd || o_mem_wr))
    else $error("bus idle too long");
  chk_done_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_instr_done |=> !o_instr_done)
    else $error("completion pulse longer than one cycle");
endmodule
bind coad_decoder coad_decoder_chk #(.AW(AW), .DW(DW)) chk_u (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_mem_ready(i_mem_ready),
  .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_rd(o_mem_rd),
  .o_mem_wr(o_mem_wr), .o_pc(o_pc), .o_acc(o_acc), .o_flags(o_flags),
  .o_instr_done(o_instr_done), .o_illegal(o_illegal));
`default_nettype wire

// *** verification/coad_decoder_tb_top.sv ***
// Self-checking testbench for the operand addressing decoder
`timescale 1ns/1ps
`default_nettype none
module coad_decoder_tb_top;
  logic        i_core_clk;
  logic        i_rst;
  logic        i_slow;
  logic [7:0]  i_mem_rdata;
  logic        i_mem_ready;
  logic [15:0] o_mem_addr;
  logic [7:0]  o_mem_wdata;
  logic        o_mem_rd;
  logic        o_mem_wr;
  logic [15:0] o_pc;
  logic [7:0]  o_acc;
  logic [7:0]  o_flags;
  logic [15:0] o_memory_pointer_pair;
  logic [15:0] o_byte_counter_pair;
  logic        o_instr_done;
  logic        o_illegal;
  int          failures;
  int          check_count;

  coad_decoder dut_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_mem_rdata(i_mem_rdata),
    .i_mem_ready(i_mem_ready), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_pc(o_pc), .o_acc(o_acc), .o_flags(o_flags),
    .o_memory_pointer_pair(o_memory_pointer_pair),
    .o_byte_counter_pair(o_byte_counter_pair),
    .o_instr_done(o_instr_done), .o_illegal(o_illegal));
  coad_mem_model mem_u (
    .i_core_clk(i_core_clk), .i_slow(i_slow), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .o_rdata(i_mem_rdata), .o_ready(i_mem_ready));

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic int pos(input logic [15:0] a);
    foreach (mem_u.rd_log[k])
      if (mem_u.rd_log[k] === a)
        return k;
    return -1;
  endfunction

  // Program bytes are right-aligned in p, first byte at address zero
  task automatic start(input logic slow, input int n, input logic [127:0] p);
    @(posedge i_core_clk);
    i_rst  <= 1'b1;
    i_slow <= slow;
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    for (int a = 0; a < 65536; a++)
      mem_u.mem[a] = 8'h00;
    for (int k = 0; k < n; k++)
      mem_u.mem[k] = p[8*(n-1-k) +: 8];
    @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(negedge i_core_clk);
    mem_u.rd_log.delete();
  endtask

  // Returns in the cycle the last completion pulse is visible
  task automatic run(input int ni);
    int seen;
    seen = 0;
    for (int t = 0; t < 4000 && seen < ni; t++) begin
      @(posedge i_core_clk);
      if (o_instr_done === 1'b1)
        seen++;
    end
    if (seen < ni) begin
      failures++;
      $display("BAD t=%0t no completion", $time);
      print_verdict();
    end
  endtask

  task automatic t_jump();
    start(1'b1, 3, 128'hC37703);
    run(1);
    chk(o_pc, 16'h0377, "jump target");
    for (int k = 0; k < 3; k++)
      chk(mem_u.rd_log[k], k, "fetch order");
    $display("test jump done");
  endtask

  task automatic t_restart();
    for (int t = 0; t < 8; t++) begin
      start(1'b0, 1, {2'b11, t[2:0], 3'b111});
      run(1);
      chk(o_pc, t * 8, "restart target");
    end
    $display("test restart done");
  endtask

  task automatic t_relative();
    logic [7:0] d [3] = '{8'h05, 8'hFE, 8'h80};
    for (int k = 0; k < 3; k++) begin
      start(1'b0, 2, {8'h18, d[k]});
      run(1);
      chk(o_pc, 16'(16'h0002 + {{8{d[k][7]}}, d[k]}), "rel");
      chk(o_pc < 16'h0002 || o_pc[15], d[k][7], "rel sign");
    end
    $display("test relative done");
  endtask

  task automatic t_load();
    start(1'b0, 6, 128'h3E7C065A782F);
    run(1);
    chk(o_acc, 8'h7C, "immediate");
    run(2);
    chk(o_acc, 8'h5A, "register copy");
    run(1);
    chk(o_acc, 8'hA5, "complement");
    $display("test load done");
  endtask

  task automatic t_indirect();
    start(1'b0, 6, 128'h2154023E1086);
    mem_u.mem[16'h0254] = 8'h22;
    run(3);
    chk(o_acc, 8'h32, "add memory");
    chk(pos(16'h0254) >= 0, 1, "pointer read");
    $display("test indirect done");
  endtask

  task automatic t_indexed();
    start(1'b1, 10, 128'hFD210010FD7E20FD7EFF);
    mem_u.mem[16'h1020] = 8'h11;
    mem_u.mem[16'h0FFF] = 8'h3C;
    run(2);
    chk(o_acc, 8'h11, "index plus");
    run(1);
    chk(o_acc, 8'h3C, "index minus");
    $display("test indexed done");
  endtask

  task automatic t_compare();
    int lo, mid, hi;
    for (int k = 0; k < 2; k++) begin
      start(1'b0, 10, k ? 128'h2102030103003E55EDB9
                        : 128'h2100030103003E55EDB1);
      // Three loads, then one completion per compare iteration
      run(6);
      lo  = pos(16'h0300);
      mid = pos(16'h0301);
      hi  = pos(16'h0302);
      chk(o_pc, 16'h000A, "compare end");
      @(posedge i_core_clk);
      chk(o_byte_counter_pair, 16'h0000, "count zero");
      chk(o_memory_pointer_pair, k ? 16'h02FF : 16'h0303,
          "pointer end");
      if (k == 0) begin
        chk(lo < mid && mid < hi, 1, "up order");
        chk(pos(16'h0303), -1, "up count");
      end else begin
        chk(hi < mid && mid < lo, 1, "down order");
        chk(pos(16'h02FF), -1, "down count");
      end
    end
    $display("test compare done");
  endtask

  task automatic t_call();
    for (int c = 0; c < 8; c++) begin
      start(1'b0, 3, {2'b11, c[2:0], 3'b100, 16'h3412});
      run(1);
      chk(o_pc, c[0] ? 16'h0003 : 16'h1234, "cond call");
    end
    $display("test call done");
  endtask

  task automatic t_bit();
    int t;
    start(1'b0, 8, 128'hCBD7CB97CB57ED00);
    run(1);
    chk(o_acc, 8'h04, "bit set");
    run(1);
    chk(o_acc, 8'h00, "bit clear");
    run(1);
    chk(o_flags[6], 1'b1, "bit test");
    chk(o_illegal, 1'b0, "legal so far");
    for (t = 0; t < 50 && o_illegal !== 1'b1; t++)
      @(posedge i_core_clk);
    chk(o_illegal, 1'b1, "unknown opcode");
    $display("test bit done");
  endtask

  task automatic t_pair();
    // First add overflows to set carry, second adds it back in
    start(1'b0, 15, 128'h2100F0010010ED4A013412ED4A2B7E);
    mem_u.mem[16'h1234] = 8'h9B;
    run(3);
    chk(o_flags[0], 1'b1, "pair carry");
    run(4);
    chk(pos(16'h1234) >= 0, 1, "pair address");
    chk(o_acc, 8'h9B, "pair load");
    $display("test pair done");
  endtask

  initial begin
    i_rst       = 1'b1;
    i_slow      = 1'b0;
    failures    = 0;
    check_count = 0;
    repeat (5) @(posedge i_core_clk);
    t_jump();
    t_restart();
    t_relative();
    t_load();
    t_indirect();
    t_indexed();
    t_compare();
    t_call();
    t_bit();
    t_pair();
    print_verdict();
  end
endmodule
`default_nettype wire

// *** verification/coad_mem_model.sv ***
// Program and data memory answering the decoder with optional wait states
`timescale 1ns/1ps
`default_nettype none
module coad_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_slow,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  output var  logic [7:0]  o_rdata,
  output var  logic        o_ready
);
  logic [7:0]  mem [0:65535];
  logic [15:0] rd_log [$];
  logic [1:0]  wait_cnt;
  initial begin
    o_rdata  = 8'hA5;
    o_ready  = 1'b0;
    wait_cnt = 2'h0;
  end
  // Data lines toggle when not answering so stale bytes never look valid
  always @(posedge i_core_clk) begin
    if (o_ready && i_rd)
      rd_log.push_back(i_addr);
    if (o_ready && i_wr)
      mem[i_addr] <= i_wdata;
    if (o_ready || !(i_rd || i_wr)) begin
      o_ready  <= 1'b0;
      wait_cnt <= 2'h0;
      o_rdata  <= ~o_rdata;
    end else if (wait_cnt == (i_slow ? 2'h2 : 2'h0)) begin
      o_ready <= 1'b1;
      o_rdata <= mem[i_addr];
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      o_rdata  <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire
